//--- design/bdc_pkg.sv
package bdc_pkg;
  // global address map of the debug space
  localparam logic [17:0] BDC_SPACE_LO    = 18'h3FF00;
  localparam logic [17:0] BDC_REG_HI      = 18'h3FF0B;
  localparam logic [17:0] BDC_STATUS_ADDR = 18'h3FF01;
  localparam logic [17:0] BDC_CCR_ADDR    = 18'h3FF06;
  localparam logic [17:0] BDC_PPR_ADDR    = 18'h3FF08;
  localparam logic [17:0] BDC_FID_ADDR    = 18'h3FF0F;
  // status register field positions
  localparam int BDC_ST_ENABLE = 7;
  localparam int BDC_ST_ACTIVE = 6;
  localparam int BDC_ST_UNSECURED_FLAG  = 1;
  // program page register fields
  localparam int BDC_PPR_PAE = 7;
  localparam int BDC_PPR_SEL_HI = 3;
  localparam logic [7:0] BDC_PPR_MASK = 8'h8F;
  // holding register reset values
  localparam logic [7:0] BDC_CCR_RST_SSC   = 8'hD8;
  localparam logic [7:0] BDC_CCR_RST_OTHER = 8'h00;
  // hardware halt opcode
  localparam logic [7:0] BDC_OP_HALT = 8'h90;
  // arbitrary neutral family identifier
  localparam logic [7:0] BDC_FAMILY_IDENTIFIER_DEF = 8'h5A;
  // delay before a refused activation lets the cpu go
  localparam int BDC_REFUSE_NS = 40;
  localparam int BDC_CLK_NS    = 10;
  localparam int BDC_REFUSE_CYC = (BDC_REFUSE_NS + BDC_CLK_NS - 1) / BDC_CLK_NS;

  // debug-side access request from the serial engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bd_space; // debug-space command variant
    logic [17:0] addr;
    logic [7:0]  wdata;
  } bdc_acc_t;

  // outgoing paging selection
  typedef struct packed {
    logic       enable;
    logic [3:0] page;
  } bdc_page_t;
endpackage

//--- design/bdc_entry_delay.sv
`timescale 1ns/1ps
// counts the short stall applied to a refused activation
module bdc_entry_delay
  import bdc_pkg::*;
#(
  parameter int CYCLES = BDC_REFUSE_CYC
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic start_in,
  output logic      busy_out
);
  logic [7:0] count;

  // load on start, count down to zero
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= 8'h00;
    end else if (start_in && count == 8'h00) begin
      count <= 8'(CYCLES);
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // busy while counting
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (start_in && count == 8'h00) || count > 8'h01;
    end
  end
endmodule

//--- design/bdc_core_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - entry copies cpu ccr into holding register
// - special single-chip reset holds 0xD8
// - other-mode reset holding register reads zero
// - holding register writable, restored on exit
// - ccr and page registers: debug access, unsecured
// - page enable bit 7 enables paging
// - debug-space commands to the register window never page
// - bits 3..0 choose the program page
// - family_identifier visible only while active
// - hardware and firmware commands from host
// - firmware commands only unsecured and active
// - hardware commands always, unless secured and not enabled
// - secure erase pass sets unsecured and enable
// - erase fail sets enable only
// - secured outside special single-chip: refuse all
// - enable must precede activation, host-written
// - halt command, halt instruction, breakpoint activate
// - entry after current instruction, breakpoint timing
// - special single-chip reset: enabled and active; secured only active
// - refused entry delays briefly, halt ignored
// - registers mapped top space, hidden from users
// - overlap entry bumps saved pc by one
// - halt opcode 0x90 acks on entry to active, one cycle before active_out
module bdc_core_ctrl
  import bdc_pkg::*;
#(
  parameter logic [7:0] FAMILY_IDENTIFIER = BDC_FAMILY_IDENTIFIER_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       special_single_in,
  input  wire logic       secured_in,
  input  wire bdc_acc_t   acc_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [7:0] cmd_opcode_in,
  input  wire logic       cmd_firmware_in,
  input  wire logic       cpu_halt_instr_in,
  input  wire logic       brk_event_in,
  input  wire logic       brk_after_in,
  input  wire logic       instr_done_in,
  input  wire logic [7:0] cpu_ccr_in,
  input  wire logic       cpu_in_fw_space_in,
  input  wire logic       erase_done_in,
  input  wire logic       erase_ok_in,
  input  wire logic       exit_in,
  input  wire logic       user_read_in,
  input  wire logic [17:0] user_addr_in,
  output logic [7:0]      rdata_out,
  output logic            rvalid_out,
  output logic            acc_refused_out,
  output logic            fw_cmd_go_out,
  output logic            hw_cmd_go_out,
  output logic [7:0]      ccr_restore_out,
  output logic            restore_ccr_out,
  output bdc_page_t       page_out,
  output logic            active_out,
  output logic            enabled_out,
  output logic            unsecured_out,
  output logic            cpu_stall_out,
  output logic            fw_overlay_out,
  output logic            secure_fw_out,
  output logic            pc_bump_out,
  output logic            ack_out,
  output logic            user_hidden_out
);
  typedef enum {
    ST_RUN,
    ST_WAIT_INSTR,
    ST_WAIT_NEXT,
    ST_ACTIVE,
    ST_SECURE_CHECK,
    ST_SECURE_LOOP
  } bdc_state_t;

  bdc_state_t state;
  logic [7:0] ccr_hold;
  logic [7:0] ppr;
  logic       refuse_start;
  logic       refuse_busy;
  logic       allowed;
  logic       trig;
  logic       halt_cmd;
  logic       hw_ok;
  logic       acc_ok;
  logic       strap_ssc;
  logic       strap_sec;
  logic       reset_seen;
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // true when addr lies in the debug register window
  function automatic logic in_reg_space(input logic [17:0] a);
    in_reg_space = a >= BDC_SPACE_LO && a <= BDC_REG_HI;
  endfunction

  // true when addr lies in the whole debug space
  function automatic logic in_debug_space(input logic [17:0] a);
    in_debug_space = a >= BDC_SPACE_LO;
  endfunction

  // mode straps caught by a clocked process after release
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reset_seen <= 1'b0;
      strap_ssc  <= 1'b0;
      strap_sec  <= 1'b0;
    end else if (!reset_seen) begin
      reset_seen <= 1'b1;
      strap_ssc  <= special_single_in;
      strap_sec  <= secured_in;
    end
  end

  assign allowed = !(strap_sec && !strap_ssc) && reset_seen;
  assign hw_ok = allowed && (unsecured_out || !strap_sec || enabled_out);
  assign acc_ok = allowed && (unsecured_out || !strap_sec);
  assign halt_cmd = cmd_valid_in && !cmd_firmware_in &&
                    cmd_opcode_in == BDC_OP_HALT && hw_ok;
  assign trig = halt_cmd || cpu_halt_instr_in || brk_event_in;
  // refused halt-instruction or breakpoint activation stalls cpu briefly
  assign refuse_start = state == ST_RUN && !enabled_out &&
                        (cpu_halt_instr_in || brk_event_in);

  bdc_entry_delay #(
    .CYCLES(BDC_REFUSE_CYC)
  ) u_delay (
    .clk_in  (clk_in),
    .reset_in(reset_in),
    .start_in(refuse_start),
    .busy_out(refuse_busy)
  );

  // activation, secure check and exit sequencing
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state         <= ST_RUN;
      enabled_out   <= 1'b0;
      unsecured_out <= 1'b0;
    end else if (!reset_seen) begin
      // unsecured special single-chip starts enabled and active
      if (special_single_in && secured_in) begin
        state <= ST_SECURE_CHECK;
      end else if (special_single_in) begin
        state       <= ST_ACTIVE;
        enabled_out <= 1'b1;
      end
      unsecured_out <= !secured_in;
    end else begin
      // host sets enable via status write
      if (acc_in.valid && acc_in.write && acc_in.bd_space && hw_ok &&
          acc_in.addr == BDC_STATUS_ADDR) begin
        enabled_out <= acc_in.wdata[BDC_ST_ENABLE];
      end
      unique case (state)
        ST_RUN: begin
          if (trig && enabled_out && allowed) begin
            state <= (brk_event_in && brk_after_in) ? ST_WAIT_NEXT
                                                    : ST_WAIT_INSTR;
          end
        end
        ST_WAIT_NEXT: begin
          if (instr_done_in) begin
            state <= ST_WAIT_INSTR;
          end
        end
        ST_WAIT_INSTR: begin
          if (instr_done_in) begin
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (exit_in) begin
            state <= ST_RUN;
          end
        end
        ST_SECURE_CHECK: begin
          if (erase_done_in && erase_ok_in) begin
            unsecured_out <= 1'b1;
            enabled_out   <= 1'b1;
            state         <= ST_ACTIVE;
          end else if (erase_done_in) begin
            enabled_out <= 1'b1;
            state       <= ST_SECURE_LOOP;
          end
        end
        ST_SECURE_LOOP: state <= ST_SECURE_LOOP;
      endcase
    end
  end

  // holding register: reset, capture, write
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ccr_hold <= BDC_CCR_RST_OTHER;
    end else if (!reset_seen) begin
      // special single-chip value / zero otherwise
      ccr_hold <= special_single_in ? BDC_CCR_RST_SSC : BDC_CCR_RST_OTHER;
    end else if (state == ST_WAIT_INSTR && instr_done_in) begin
      ccr_hold <= cpu_ccr_in;
    end else if (acc_in.valid && acc_in.write && acc_ok &&
                 acc_in.bd_space && acc_in.addr == BDC_CCR_ADDR) begin
      ccr_hold <= acc_in.wdata;
    end
  end

  // page register written by debug accesses only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ppr <= 8'h00;
    end else if (acc_in.valid && acc_in.write && acc_ok &&
                 acc_in.bd_space && acc_in.addr == BDC_PPR_ADDR) begin
      ppr <= acc_in.wdata & BDC_PPR_MASK;
    end
  end

  // read data path for debug accesses
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out       <= 8'h00;
      rvalid_out      <= 1'b0;
      acc_refused_out <= 1'b0;
    end else begin
      rvalid_out      <= acc_in.valid && !acc_in.write && acc_ok;
      acc_refused_out <= acc_in.valid && !acc_ok;
      rdata_out       <= 8'h00;
      if (acc_in.valid && !acc_in.write && acc_ok && acc_in.bd_space) begin
        if (acc_in.addr == BDC_CCR_ADDR) begin
          rdata_out <= ccr_hold;
        end else if (acc_in.addr == BDC_PPR_ADDR) begin
          rdata_out <= ppr;
        end else if (acc_in.addr == BDC_STATUS_ADDR) begin
          rdata_out <= {enabled_out, active_out, 4'h0, unsecured_out, 1'b0};
        end else if (acc_in.addr == BDC_FID_ADDR && active_out) begin
          rdata_out <= FAMILY_IDENTIFIER;
        end
      end
    end
  end

  // paging selection for memory accesses
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_out <= '0;
    end else begin
      // enable bit / debug register window never pages
      page_out.enable <= ppr[BDC_PPR_PAE] &&
                         !(acc_in.valid && acc_in.bd_space &&
                           in_reg_space(acc_in.addr));
      page_out.page <= ppr[BDC_PPR_SEL_HI:0];
    end
  end

  // command gating, status and cpu control outputs
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fw_cmd_go_out   <= 1'b0;
      hw_cmd_go_out   <= 1'b0;
      ccr_restore_out <= 8'h00;
      restore_ccr_out <= 1'b0;
      active_out      <= 1'b0;
      cpu_stall_out   <= 1'b0;
      fw_overlay_out  <= 1'b0;
      secure_fw_out   <= 1'b0;
      pc_bump_out     <= 1'b0;
      ack_out         <= 1'b0;
      user_hidden_out <= 1'b0;
    end else begin
      // two command classes / firmware gating
      fw_cmd_go_out <= cmd_valid_in && cmd_firmware_in && acc_ok &&
                       state == ST_ACTIVE;
      hw_cmd_go_out <= cmd_valid_in && !cmd_firmware_in && hw_ok &&
                       !(halt_cmd && !enabled_out);
      ccr_restore_out <= ccr_hold;
      restore_ccr_out <= state == ST_ACTIVE && exit_in;
      active_out     <= state == ST_ACTIVE || state == ST_SECURE_CHECK ||
                        state == ST_SECURE_LOOP;
      cpu_stall_out  <= refuse_busy;
      fw_overlay_out <= state == ST_ACTIVE;
      secure_fw_out  <= state == ST_SECURE_CHECK ||
                        state == ST_SECURE_LOOP;
      // entry inside firmware space bumps pc
      pc_bump_out <= state == ST_WAIT_INSTR && instr_done_in &&
                     cpu_in_fw_space_in;
      // ack on entry to active, after any trigger
      ack_out <= state == ST_WAIT_INSTR && instr_done_in;
      // user reads of debug space hidden
      user_hidden_out <= user_read_in && in_debug_space(user_addr_in);
    end
  end

  a_fid_hidden: assert property (
    (acc_in.valid && acc_in.bd_space && !acc_in.write && !active_out &&
     acc_in.addr == BDC_FID_ADDR) |=> rdata_out == 8'h00)
    else $error("family_identifier visible while inactive");
  a_fw_gate: assert property (
    fw_cmd_go_out |-> $past(state) == ST_ACTIVE && $past(unsecured_out))
    else $error("firmware command outside active mode");
  a_ccr_capture: assert property (
    (state == ST_WAIT_INSTR && instr_done_in) |=>
    ccr_hold == $past(cpu_ccr_in))
    else $error("ccr not captured on entry");
  a_halt_ignored: assert property (
    (state == ST_RUN && !enabled_out && halt_cmd && !refuse_busy) |=>
    state == ST_RUN && !cpu_stall_out && !hw_cmd_go_out)
    else $error("halt while disabled not ignored");
  a_reg_nopage: assert property (
    (acc_in.valid && acc_in.bd_space && in_reg_space(acc_in.addr)) |=>
    !page_out.enable)
    else $error("paged access on debug register space");
  a_ack_active: assert property (
    $rose(ack_out) |-> ##1 active_out)
    else $error("ack without activation");
  a_fail_enable: assert property (
    (state == ST_SECURE_CHECK && erase_done_in && !erase_ok_in) |=>
    enabled_out && !unsecured_out)
    else $error("erase fail handling wrong");
  a_pass_unsecured_flag: assert property (
    (state == ST_SECURE_CHECK && erase_done_in && erase_ok_in) |=>
    enabled_out && unsecured_out)
    else $error("erase pass handling wrong");
endmodule

//--- verification/bdc_host_model.sv
`timescale 1ns/1ps
// host debugger side: register accesses and decoded commands
module bdc_host_model
  import bdc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  input  wire logic       refused_in,
  output bdc_acc_t        acc_out,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_opcode_out,
  output logic            cmd_firmware_out
);
  // idle values at time zero
  initial begin
    acc_out = '0;
    cmd_valid_out = 1'b0;
    cmd_opcode_out = 8'h00;
    cmd_firmware_out = 1'b0;
  end

  // byte access held until the taking edge
  task automatic access(input logic wr, input logic [17:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic rf);
    int n;
    acc_out = '{valid: 1'b1, write: wr, bd_space: 1'b1, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
    // released lines show the inverse of the last value
    acc_out = '{valid: 1'b0, write: ~wr, bd_space: 1'b0, addr: ~a,
                wdata: ~d};
    for (n = 0; n < 3; n++) begin
      if (rvalid_in === 1'b1 || refused_in === 1'b1) break;
      @(posedge clk_in);
      #1;
    end
    q = rdata_in;
    rf = refused_in;
    @(posedge clk_in);
    #1;
  endtask

  // one decoded command, hardware or firmware
  task automatic cmd(input logic [7:0] op, input logic fw);
    cmd_valid_out = 1'b1;
    cmd_opcode_out = op;
    cmd_firmware_out = fw;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_opcode_out = ~op;
    cmd_firmware_out = ~fw;
  endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
// directed bench for the debug control core
module tb_top
  import bdc_pkg::*;
;
  logic clk_in = 1'b0, reset_in = 1'b1, ssc = 1'b0, sec = 1'b0;
  logic halt_i = 1'b0, brk = 1'b0, idone = 1'b0, fws = 1'b0;
  logic edone = 1'b0, eok = 1'b0, ex = 1'b0, uread = 1'b0;
  logic [7:0] condition_code_register = 8'h00, rdata, q, seen;
  logic rvalid, refd, fwgo, hwgo, rst_ccr, act, ena, uns, stall;
  logic sfw, bump, ack, hid, rf;
  logic ovl, baft = 1'b0;
  logic [17:0] uaddr = BDC_CCR_ADDR;
  logic [7:0] ccr_out;
  bdc_page_t page;
  bdc_acc_t acc;
  logic cv, cf;
  logic [7:0] cop;
  int miscompares = 0, checks_done = 0;

  // clock at 100 MHz
  always #5 clk_in = ~clk_in;

  bdc_host_model i_bdc_host_model (.clk_in(clk_in), .rdata_in(rdata),
    .rvalid_in(rvalid), .refused_in(refd), .acc_out(acc),
    .cmd_valid_out(cv), .cmd_opcode_out(cop), .cmd_firmware_out(cf));

  bdc_core_ctrl i_bdc_core_ctrl (.clk_in(clk_in), .reset_in(reset_in),
    .special_single_in(ssc), .secured_in(sec), .acc_in(acc),
    .cmd_valid_in(cv), .cmd_opcode_in(cop), .cmd_firmware_in(cf),
    .cpu_halt_instr_in(halt_i), .brk_event_in(brk), .brk_after_in(baft),
    .instr_done_in(idone), .cpu_ccr_in(condition_code_register), .cpu_in_fw_space_in(fws),
    .erase_done_in(edone), .erase_ok_in(eok), .exit_in(ex),
    .user_read_in(uread), .user_addr_in(uaddr), .rdata_out(rdata),
    .rvalid_out(rvalid), .acc_refused_out(refd), .fw_cmd_go_out(fwgo),
    .hw_cmd_go_out(hwgo), .ccr_restore_out(ccr_out),
    .restore_ccr_out(rst_ccr), .page_out(page), .active_out(act),
    .enabled_out(ena), .unsecured_out(uns), .cpu_stall_out(stall),
    .fw_overlay_out(ovl), .secure_fw_out(sfw), .pc_bump_out(bump),
    .ack_out(ack), .user_hidden_out(hid));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // strap the mode, hold reset four cycles
  task automatic do_reset(input logic s, input logic c);
    ssc = s;
    sec = c;
    reset_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // gather output pulses: ack fw hw restore bump hidden stall active
  task automatic watch(input int n);
    seen |= {ack, fwgo, hwgo, rst_ccr, bump, hid, stall, act};
    repeat (n) begin
      @(posedge clk_in);
      #1;
      seen |= {ack, fwgo, hwgo, rst_ccr, bump, hid, stall, act};
    end
  endtask

  task automatic rd(input logic [17:0] a);
    i_bdc_host_model.access(1'b0, a, 8'h00, q, rf);
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    i_bdc_host_model.access(1'b1, a, d, q, rf);
  endtask

  // watchdog
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  initial begin
    do_reset(1'b0, 1'b0);
    rd(BDC_CCR_ADDR);
    check(q, 8'h00);
    rd(BDC_FID_ADDR);
    check(q, 8'h00);
    seen = '0;
    i_bdc_host_model.cmd(BDC_OP_HALT, 1'b0);
    watch(8);
    check(seen, 8'h00);
    i_bdc_host_model.cmd(8'h63, 1'b1);
    watch(1);
    i_bdc_host_model.cmd(8'hE4, 1'b0);
    watch(3);
    check(seen, 8'h20);
    seen = '0;
    halt_i = 1'b1;
    brk = 1'b1;
    watch(1);
    halt_i = 1'b0;
    brk = 1'b0;
    watch(6);
    check(seen & 8'h03, 8'h02);
    $display("test 1 done");
    wr(BDC_STATUS_ADDR, 8'h80);
    rd(BDC_STATUS_ADDR);
    check(q & 8'h80, 8'h80);
    wr(BDC_PPR_ADDR, 8'h85);
    rd(BDC_PPR_ADDR);
    check(q, 8'h85);
    check({3'b000, page}, 8'h15);
    wr(BDC_PPR_ADDR, 8'h7F);
    rd(BDC_PPR_ADDR);
    check(q, 8'h0F);
    check({3'b000, page}, 8'h0F);
    $display("test 2 done");
    condition_code_register = 8'h3C;
    fws = 1'b1;
    seen = '0;
    i_bdc_host_model.cmd(BDC_OP_HALT, 1'b0);
    idone = 1'b1;
    watch(1);
    idone = 1'b0;
    watch(4);
    check(seen & 8'h89, 8'h89);
    rd(BDC_CCR_ADDR);
    check(q, 8'h3C);
    rd(BDC_FID_ADDR);
    check(q, BDC_FAMILY_IDENTIFIER_DEF);
    check({7'h00, ovl}, 8'h01);
    seen = '0;
    i_bdc_host_model.cmd(8'h63, 1'b1);
    uread = 1'b1;
    watch(1);
    uread = 1'b0;
    watch(3);
    check(seen & 8'h44, 8'h44);
    uaddr = 18'h00100;
    seen = '0;
    uread = 1'b1;
    watch(1);
    uread = 1'b0;
    watch(1);
    check(seen & 8'h04, 8'h00);
    wr(BDC_CCR_ADDR, 8'h11);
    seen = '0;
    ex = 1'b1;
    watch(1);
    ex = 1'b0;
    watch(3);
    check(seen & 8'h10, 8'h10);
    check(ccr_out, 8'h11);
    check({7'h00, ovl}, 8'h00);
    seen = '0;
    brk = 1'b1;
    baft = 1'b1;
    watch(1);
    brk = 1'b0;
    baft = 1'b0;
    idone = 1'b1;
    watch(1);
    idone = 1'b0;
    watch(3);
    check(seen & 8'h81, 8'h00);
    idone = 1'b1;
    watch(1);
    idone = 1'b0;
    watch(3);
    check(seen & 8'h81, 8'h81);
    $display("test 3 done");
    do_reset(1'b1, 1'b0);
    check({6'd0, ena, act}, 8'h03);
    rd(BDC_CCR_ADDR);
    check(q, BDC_CCR_RST_SSC);
    $display("test 4 done");
    do_reset(1'b1, 1'b1);
    check({7'd0, sfw}, 8'h01);
    eok = 1'b1;
    edone = 1'b1;
    watch(1);
    edone = 1'b0;
    watch(3);
    check({6'd0, uns, ena}, 8'h03);
    do_reset(1'b1, 1'b1);
    eok = 1'b0;
    edone = 1'b1;
    watch(1);
    edone = 1'b0;
    watch(3);
    check({6'd0, uns, ena}, 8'h01);
    seen = '0;
    i_bdc_host_model.cmd(8'h63, 1'b1);
    watch(1);
    i_bdc_host_model.cmd(8'hE4, 1'b0);
    watch(3);
    check(seen & 8'h60, 8'h20);
    $display("test 5 done");
    do_reset(1'b0, 1'b1);
    rd(BDC_PPR_ADDR);
    check({7'd0, rf}, 8'h01);
    $display("test 6 done");
    end_of_test();
  end
endmodule
